// ### pkg/pin_change_defines.svh
// Purpose: Constants for the pin-change interrupt block.
// Assumes: Register indexes are word indexes; byte address is four times.
// Notes: Definitions only.
`ifndef PIN_CHANGE_DEFINES_SVH
`define PIN_CHANGE_DEFINES_SVH

// ==========================================================================
// Register indexes
`define IDX_W 8
`define IDX_GRP_CTRL 8'h68
`define IDX_GRP0_MASK 8'h6b
`define IDX_GRP1_MASK 8'h6c
`define IDX_GRP2_MASK 8'h6d
`define IDX_FLAGS 8'h6e
`define IDX_EVT_STATUS 8'h70
`define IDX_EVT_MASK 8'h71

// ==========================================================================
// Bus and field layout
`define AXI_ADDR_W 10
`define AXI_DATA_W 32
`define IDX_LO 2
`define IDX_HI 9
`define REG_W 8
`define REG_RST 8'h00
`define GRP1_MASK_USED 8'h7f
`define GRP_N 3
`define GRP_RST 3'h0
`define PIN_N 24
`define PIN_RST 24'h000000
`define G0_LO 0
`define G0_HI 7
`define G1_LO 8
`define G1_HI 14
`define G2_LO 16
`define G2_HI 23
`define GRP0 0
`define GRP1 1
`define GRP2 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### pkg/pin_change_pkg.sv
// Purpose: Types shared by the pin-change interrupt block.
// Assumes: Nothing beyond the defines header.
// Notes: Write steps via WR_ADDR or WR_DATA change one state bit; entering or leaving WR_RESP from WR_IDLE changes both.
package pin_change_pkg;

  // ========================================================================
  // Write channel state
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ADDR = 2'b01,
    WR_RESP = 2'b11,
    WR_DATA = 2'b10
  } wr_state_t;

endpackage

// ### design/pin_change_detect.sv
// Purpose: Per-pin change detection gated by mask and group enable.
// Assumes: Pins are synchronous to i_clk; bit 15 has no pin.
// Notes: No change is reported on the first cycle after reset.
`timescale 1ns/10ps
`include "pin_change_defines.svh"
module pin_change_detect import pin_change_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`PIN_N-1:0] i_pins,
  input wire logic [`PIN_N-1:0] i_mask,
  input wire logic [`GRP_N-1:0] i_grp_en,
  output logic [`GRP_N-1:0] o_group_hit
);

  logic [`PIN_N-1:0] prev_r;
  logic primed_r;
  logic [`PIN_N-1:0] pin_en;
  logic [`PIN_N-1:0] change;

  // ========================================================================
  // Sample history
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_r <= `PIN_RST;
      primed_r <= 1'b0;
    end else begin
      prev_r <= i_pins;
      primed_r <= 1'b1;
    end
  end

  // ========================================================================
  // Per-pin enable and edge compare
  genvar n;
  generate
    for (n = 0; n < `PIN_N; n = n + 1) begin : g_pin
      localparam int GRP = (n > `G1_HI) ? `GRP2 :
                           (n > `G0_HI) ? `GRP1 : `GRP0;
      // A cleared mask bit or group enable hides this pin.
      assign pin_en[n] = i_mask[n] & i_grp_en[GRP];
      // Either direction of transition counts as a change.
      assign change[n] = primed_r & pin_en[n] &
                         (i_pins[n] ^ prev_r[n]);
    end
  endgenerate

  assign o_group_hit[`GRP0] = |change[`G0_HI:`G0_LO];
  assign o_group_hit[`GRP1] = |change[`G1_HI:`G1_LO];
  assign o_group_hit[`GRP2] = |change[`G2_HI:`G2_LO];

  // ========================================================================
  // Checks
  a_edge_detect:
    assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(i_pins[`G2_LO]) && $past(primed_r) && i_mask[`G2_LO] &&
      i_grp_en[`GRP2] |-> o_group_hit[`GRP2])
    else $error("Enabled pin change not reported");

  a_group_gate:
    assert property (@(posedge i_clk) disable iff (i_rst)
      !i_grp_en[`GRP0] |-> !o_group_hit[`GRP0])
    else $error("Disabled group reported a change");

endmodule

// ### design/axil_reg_slave.sv
// Purpose: AXI4-Lite slave turning transfers into register strobes.
// Assumes: One write and one read outstanding at most.
// Notes: Both answers come one cycle after the request is complete.
`timescale 1ns/10ps
`include "pin_change_defines.svh"
module axil_reg_slave import pin_change_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [`AXI_ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [`AXI_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [`AXI_ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [`AXI_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_wr_en,
  output logic [`IDX_W-1:0] o_wr_idx,
  output logic [`REG_W-1:0] o_wr_data,
  output logic o_rd_en,
  output logic [`IDX_W-1:0] o_rd_idx,
  input wire logic [`REG_W-1:0] i_rd_data,
  input wire logic i_rd_hit,
  input wire logic i_wr_hit
);

  wr_state_t wr_state_r, wr_state_nxt;
  logic [`IDX_W-1:0] aw_idx_r;
  logic [`REG_W-1:0] w_data_r;
  logic w_lane_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [`AXI_DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  // ========================================================================
  // Write channel decode
  wire aw_fire = i_awvalid & o_awready;
  wire w_fire = i_wvalid & o_wready;
  wire have_aw = aw_fire | (wr_state_r == WR_ADDR);
  wire have_w = w_fire | (wr_state_r == WR_DATA);
  wire wr_lane = w_fire ? i_wstrb[0] : w_lane_r;
  wire wr_done = have_aw & have_w & (wr_state_r != WR_RESP);

  assign o_awready = (wr_state_r == WR_IDLE) | (wr_state_r == WR_DATA);
  assign o_wready = (wr_state_r == WR_IDLE) | (wr_state_r == WR_ADDR);
  assign o_wr_idx = aw_fire ? i_awaddr[`IDX_HI:`IDX_LO] : aw_idx_r;
  assign o_wr_data = w_fire ? i_wdata[`REG_W-1:0] : w_data_r;
  // Only byte lane 0 carries register bits; other lanes are dropped.
  assign o_wr_en = wr_done & wr_lane;
  assign o_bvalid = (wr_state_r == WR_RESP);
  assign o_bresp = bresp_r;

  always_comb begin
    wr_state_nxt = wr_state_r;
    case (wr_state_r)
      WR_IDLE: begin
        if (wr_done) begin
          wr_state_nxt = WR_RESP;
        end else if (aw_fire) begin
          wr_state_nxt = WR_ADDR;
        end else if (w_fire) begin
          wr_state_nxt = WR_DATA;
        end
      end
      WR_ADDR, WR_DATA: begin
        if (wr_done) begin
          wr_state_nxt = WR_RESP;
        end
      end
      WR_RESP: begin
        if (i_bready) begin
          wr_state_nxt = WR_IDLE;
        end
      end
      default: wr_state_nxt = WR_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_state_r <= WR_IDLE;
      aw_idx_r <= `REG_RST;
      w_data_r <= `REG_RST;
      w_lane_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      wr_state_r <= wr_state_nxt;
      aw_idx_r <= o_wr_idx;
      w_data_r <= o_wr_data;
      w_lane_r <= wr_lane;
      if (wr_done) begin
        bresp_r <= i_wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ========================================================================
  // Read channel
  assign o_arready = ~rvalid_r;
  assign o_rd_en = i_arvalid & o_arready;
  assign o_rd_idx = i_araddr[`IDX_HI:`IDX_LO];
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= {`AXI_DATA_W{1'b0}};
      rresp_r <= `RESP_OKAY;
    end else if (o_rd_en) begin
      rvalid_r <= 1'b1;
      rdata_r <= {{(`AXI_DATA_W-`REG_W){1'b0}}, i_rd_data};
      rresp_r <= i_rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// ### design/pin_change_irq.sv
// Purpose: Pin-change interrupt flags, masks and vector requests.
// Assumes: Pins are synchronous to i_clk; the processor pulses
//   i_vector_ack for one cycle when a group's routine starts.
// Notes: Registers sit on AXI4-Lite at four times their word index.
//
// Function
// - Enabled change on pins 16..23 sets group 2 flag.
// - Enabled change on pins 8..14 sets group 1 flag.
// - Enabled change on pins 0..7 sets group 0 flag.
// - Set flag plus global and group enable requests that group's vector.
// - Executing a group's vector clears that group's flag.
// - Writing one to a flag clears it; writing zero leaves it.
// - Group 2 mask bits enable pins 16..23 when group 2 enabled.
// - Group 1 mask bits 6..0 enable pins 8..14 when group enabled.
// - Group 0 mask bits enable pins 0..7 when group 0 enabled.
// - A zero mask bit makes its pin's changes ignored.
// - Flag register bits 7..3 always read zero.
// - Group 1 mask bit 7 reads zero and ignores writes.
// - Control bits 0..2 enable each group with global enable.
`timescale 1ns/10ps
`include "pin_change_defines.svh"
module pin_change_irq import pin_change_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`PIN_N-1:0] i_pins,
  input wire logic i_global_irq_enable,
  input wire logic [`GRP_N-1:0] i_vector_ack,
  output logic [`GRP_N-1:0] o_vector_req,
  output logic o_irq,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [`AXI_ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [`AXI_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [`AXI_ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [`AXI_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp
);

  logic [`REG_W-1:0] grp0_pin_mask_r;
  logic [`REG_W-1:0] grp1_pin_mask_r;
  logic [`REG_W-1:0] grp2_pin_mask_r;
  logic [`GRP_N-1:0] grp_enable_r;
  logic [`GRP_N-1:0] flags_r, flags_nxt;
  logic [`GRP_N-1:0] evt_status_r, evt_status_nxt;
  logic [`GRP_N-1:0] evt_mask_r;
  logic [`GRP_N-1:0] group_hit;
  logic wr_en;
  logic [`IDX_W-1:0] wr_idx;
  logic [`REG_W-1:0] wr_data;
  logic rd_en;
  logic [`IDX_W-1:0] rd_idx;
  logic [`REG_W-1:0] rd_data;
  logic rd_hit;
  logic wr_hit;

  // ========================================================================
  // Bus slave
  axil_reg_slave u_bus (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .o_bresp(o_bresp),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .i_araddr(i_araddr),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_wr_en(wr_en),
    .o_wr_idx(wr_idx),
    .o_wr_data(wr_data),
    .o_rd_en(rd_en),
    .o_rd_idx(rd_idx),
    .i_rd_data(rd_data),
    .i_rd_hit(rd_hit),
    .i_wr_hit(wr_hit)
  );

  // ========================================================================
  // Change detection
  // Bit 15 has no pin, and group 1 mask bit 7 is held at zero.
  wire [`PIN_N-1:0] pin_mask = {grp2_pin_mask_r, grp1_pin_mask_r,
                                grp0_pin_mask_r};

  pin_change_detect u_detect (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pins(i_pins),
    .i_mask(pin_mask),
    .i_grp_en(grp_enable_r),
    .o_group_hit(group_hit)
  );

  // ========================================================================
  // Address decode
  wire sel_w_ctrl = wr_en & (wr_idx == `IDX_GRP_CTRL);
  wire sel_w_m0 = wr_en & (wr_idx == `IDX_GRP0_MASK);
  wire sel_w_m1 = wr_en & (wr_idx == `IDX_GRP1_MASK);
  wire sel_w_m2 = wr_en & (wr_idx == `IDX_GRP2_MASK);
  wire sel_w_flags = wr_en & (wr_idx == `IDX_FLAGS);
  wire sel_w_emask = wr_en & (wr_idx == `IDX_EVT_MASK);
  wire sel_r_status = rd_en & (rd_idx == `IDX_EVT_STATUS);

  function automatic logic idx_known(input logic [`IDX_W-1:0] idx);
    idx_known = (idx == `IDX_GRP_CTRL) | (idx == `IDX_GRP0_MASK) |
                (idx == `IDX_GRP1_MASK) | (idx == `IDX_GRP2_MASK) |
                (idx == `IDX_FLAGS) | (idx == `IDX_EVT_STATUS) |
                (idx == `IDX_EVT_MASK);
  endfunction

  assign wr_hit = idx_known(wr_idx);
  assign rd_hit = idx_known(rd_idx);

  // Narrow registers fill the low bits; unused bits read as zero.
  wire [`REG_W-1:0] rd_ctrl = {{(`REG_W-`GRP_N){1'b0}}, grp_enable_r};
  wire [`REG_W-1:0] rd_flags =
    {{(`REG_W-`GRP_N){1'b0}}, flags_r};
  wire [`REG_W-1:0] rd_status = {{(`REG_W-`GRP_N){1'b0}}, evt_status_r};
  wire [`REG_W-1:0] rd_emask = {{(`REG_W-`GRP_N){1'b0}}, evt_mask_r};

  assign rd_data = (rd_idx == `IDX_GRP_CTRL) ? rd_ctrl :
                   (rd_idx == `IDX_GRP0_MASK) ? grp0_pin_mask_r :
                   (rd_idx == `IDX_GRP1_MASK) ? grp1_pin_mask_r :
                   (rd_idx == `IDX_GRP2_MASK) ? grp2_pin_mask_r :
                   (rd_idx == `IDX_FLAGS) ? rd_flags :
                   (rd_idx == `IDX_EVT_STATUS) ? rd_status :
                   (rd_idx == `IDX_EVT_MASK) ? rd_emask : `REG_RST;

  // ========================================================================
  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      grp0_pin_mask_r <= `REG_RST;
      grp1_pin_mask_r <= `REG_RST;
      grp2_pin_mask_r <= `REG_RST;
      grp_enable_r <= `GRP_RST;
      evt_mask_r <= `GRP_RST;
    end else begin
      if (sel_w_m0) begin
        grp0_pin_mask_r <= wr_data;
      end
      if (sel_w_m1) begin
        grp1_pin_mask_r <= wr_data & `GRP1_MASK_USED;
      end
      if (sel_w_m2) begin
        grp2_pin_mask_r <= wr_data;
      end
      if (sel_w_ctrl) begin
        grp_enable_r <= wr_data[`GRP_N-1:0];
      end
      if (sel_w_emask) begin
        evt_mask_r <= wr_data[`GRP_N-1:0];
      end
    end
  end

  // ========================================================================
  // Group flags and event status
  wire [`GRP_N-1:0] flag_w1c = sel_w_flags ? wr_data[`GRP_N-1:0] :
                                             `GRP_RST;

  always_comb begin
    // A new change beats a clear arriving in the same cycle.
    flags_nxt = (flags_r & ~flag_w1c & ~i_vector_ack) |
                group_hit;
    evt_status_nxt = (sel_r_status ? `GRP_RST : evt_status_r) | group_hit;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags_r <= `GRP_RST;
      evt_status_r <= `GRP_RST;
    end else begin
      flags_r <= flags_nxt;
      evt_status_r <= evt_status_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign o_vector_req = flags_r & grp_enable_r &
                        {`GRP_N{i_global_irq_enable}};
  assign o_irq = |(evt_status_r & evt_mask_r);

  // ========================================================================
  // Checks
  a_group2_set:
    assert property (@(posedge i_clk) disable iff (i_rst)
      group_hit[`GRP2] |=> flags_r[`GRP2])
    else $error("Group 2 change did not set its flag");

  a_group1_set:
    assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(i_pins[`G1_HI]) && grp1_pin_mask_r[`G1_HI-`G1_LO] &&
      grp_enable_r[`GRP1] && !$past(i_rst) |=> flags_r[`GRP1])
    else $error("Group 1 change did not set its flag");

  a_group0_set:
    assert property (@(posedge i_clk) disable iff (i_rst)
      group_hit[`GRP0] |=> flags_r[`GRP0] && evt_status_r[`GRP0])
    else $error("Group 0 change did not set flag and status");

  a_vector_req:
    assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(flags_r[`GRP2]) && grp_enable_r[`GRP2] && i_global_irq_enable
      |-> o_vector_req[`GRP2])
    else $error("Set flag did not request its vector");

  a_vector_clear:
    assert property (@(posedge i_clk) disable iff (i_rst)
      i_vector_ack[`GRP0] && !group_hit[`GRP0] |=> !flags_r[`GRP0])
    else $error("Vector execution left the flag set");

  a_w1c_clear:
    assert property (@(posedge i_clk) disable iff (i_rst)
      sel_w_flags && wr_data[`GRP1] && !group_hit[`GRP1]
      |=> !flags_r[`GRP1])
    else $error("Writing one did not clear the flag");

  a_w0_keep:
    assert property (@(posedge i_clk) disable iff (i_rst)
      sel_w_flags && !wr_data[`GRP1] && !i_vector_ack[`GRP1] &&
      flags_r[`GRP1] |=> flags_r[`GRP1])
    else $error("Writing zero changed the flag");

  a_mask_ignore:
    assert property (@(posedge i_clk) disable iff (i_rst)
      ((i_pins[`G0_HI:`G0_LO] ^ $past(i_pins[`G0_HI:`G0_LO])) &
       grp0_pin_mask_r) == `REG_RST |-> !group_hit[`GRP0])
    else $error("Masked pins still raised a change");

  a_flags_rsvd:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_rvalid && $past(rd_en) && $past(rd_idx) == `IDX_FLAGS
      |-> o_rdata[`REG_W-1:`GRP_N] == '0)
    else $error("Unused flag bits read nonzero");

  a_mask1_rsvd:
    assert property (@(posedge i_clk) disable iff (i_rst)
      !grp1_pin_mask_r[`REG_W-1])
    else $error("Group 1 mask bit 7 became set");

  a_set_wins:
    assert property (@(posedge i_clk) disable iff (i_rst)
      group_hit[`GRP0] && (flag_w1c[`GRP0] || i_vector_ack[`GRP0])
      |=> flags_r[`GRP0] ##1 flags_r[`GRP0] || !$past(flags_r[`GRP0]) ||
      $past(flag_w1c[`GRP0] | i_vector_ack[`GRP0]))
    else $error("Clear beat a simultaneous change");

  a_flag_hold:
    assert property (@(posedge i_clk) disable iff (i_rst)
      flags_r[`GRP2] && !flag_w1c[`GRP2] && !i_vector_ack[`GRP2]
      |=> flags_r[`GRP2])
    else $error("Group 2 flag dropped without a clear");

  a_ack_hold:
    assert property (@(posedge i_clk) disable iff (i_rst)
      flags_r[`GRP0] && !flag_w1c[`GRP0] && !i_vector_ack[`GRP0]
      |=> flags_r[`GRP0])
    else $error("Group 0 flag dropped without a clear");

  a_no_spurious:
    assert property (@(posedge i_clk) disable iff (i_rst)
      !flags_r[`GRP1] && !group_hit[`GRP1] |=> !flags_r[`GRP1])
    else $error("Group 1 flag set without a change");

  a_req_gated:
    assert property (@(posedge i_clk) disable iff (i_rst)
      !i_global_irq_enable |-> o_vector_req == `GRP_RST)
    else $error("Vector requested with global enable low");

  a_status_set:
    assert property (@(posedge i_clk) disable iff (i_rst)
      group_hit[`GRP2] |=> evt_status_r[`GRP2])
    else $error("Group 2 change did not set its status");

  a_status_clear:
    assert property (@(posedge i_clk) disable iff (i_rst)
      sel_r_status && !group_hit[`GRP1] |=> !evt_status_r[`GRP1])
    else $error("Status read did not clear the status");

endmodule

// ### verif/vector_host.sv
// Purpose: Processor model that runs the routine of a requested vector.
// Assumes: One routine at a time; the lowest requesting group goes first.
// Notes: i_delay sets how many cycles pass before a routine starts.
`timescale 1ns/10ps
module vector_host (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic [3:0] i_delay,
  input wire logic [2:0] i_vector_req,
  output logic [2:0] o_vector_ack
);
  logic [3:0] wait_r;
  logic idle;
  logic [2:0] first_req;

  // ====================
  // Routine start
  assign first_req = i_vector_req & (~i_vector_req + 3'h1);
  assign idle = !i_enable || i_vector_req == 3'h0 || o_vector_ack != 3'h0;

  always_ff @(posedge i_clk) begin
    if (i_rst || idle) begin
      wait_r <= 4'h0;
      o_vector_ack <= 3'h0;
    end else if (wait_r >= i_delay) begin
      wait_r <= 4'h0;
      o_vector_ack <= first_req;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ### verif/testbench.sv
// Purpose: Self-checking bench for the pin-change interrupt block.
// Assumes: Byte address is four times the register word index.
// Notes: Register rows first, then pin, vector and reset tests.
`timescale 1ns/10ps
`include "pin_change_defines.svh"
module testbench;
  typedef struct {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] pins = 24'h000000;
  logic gie = 1'b0;
  logic host_en = 1'b0;
  logic [3:0] host_dly = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic [2:0] ack, req;
  logic irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, data;
  logic [23:0] live [3] = '{24'h000001, 24'h004000, 24'h010000};
  logic [23:0] quiet [3] = '{24'h000002, 24'h008000, 24'h040000};
  row_t rows [7] = '{
    '{8'h6b, 8'ha5, 8'ha5, `RESP_OKAY},
    '{8'h6c, 8'hff, 8'h7f, `RESP_OKAY},
    '{8'h6d, 8'h5b, 8'h5b, `RESP_OKAY},
    '{8'h68, 8'hff, 8'h07, `RESP_OKAY},
    '{8'h6e, 8'hff, 8'h00, `RESP_OKAY},
    '{8'h71, 8'h07, 8'h07, `RESP_OKAY},
    '{8'h40, 8'hff, 8'h00, `RESP_SLVERR}
  };
  int miscompares = 0;
  int checked = 0;
  int nacks = 0;
  int n;

  always #25 clk = ~clk;

  pin_change_irq i_pin_change_irq (
    .i_clk(clk), .i_rst(rst), .i_pins(pins), .i_global_irq_enable(gie),
    .i_vector_ack(ack), .o_vector_req(req), .o_irq(irq),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp)
  );
  vector_host i_vector_host (
    .i_clk(clk), .i_rst(rst), .i_enable(host_en), .i_delay(host_dly),
    .i_vector_req(req), .o_vector_ack(ack)
  );

  // ====================
  // Tasks
  task automatic stop_test();
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic hang();
    $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    miscompares++;
    stop_test();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= {idx, 2'b00};
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      if (!ar_ok && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  // ====================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    gie <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, resp);
      chk(32'(resp), 32'(rows[i].resp));
      rd(rows[i].idx, data, resp);
      chk(data, 32'(rows[i].rd));
      chk(32'(resp), 32'(rows[i].resp));
    end
    $display("Register table test done");
    for (int g = 0; g < 3; g++) begin
      pins <= pins ^ quiet[g];
      cyc(3);
      chk(32'(req), 32'h0);
      pins <= pins ^ live[g];
      cyc(3);
      chk(32'(req), 32'h1 << g);
      chk(32'(irq), 32'h1);
      rd(`IDX_EVT_STATUS, data, resp);
      chk(data, 32'h1 << g);
      rd(`IDX_EVT_STATUS, data, resp);
      chk(data, 32'h0);
      chk(32'(irq), 32'h0);
      wr(`IDX_FLAGS, 8'h00, resp);
      rd(`IDX_FLAGS, data, resp);
      chk(data, 32'h1 << g);
      wr(`IDX_FLAGS, 8'h01 << g, resp);
      rd(`IDX_FLAGS, data, resp);
      chk(data, 32'h0);
      $display("Group %0d pin test done", g);
    end
    gie <= 1'b0;
    pins <= pins ^ live[0];
    cyc(3);
    chk(32'(req), 32'h0);
    rd(`IDX_FLAGS, data, resp);
    chk(data, 32'h1);
    gie <= 1'b1;
    cyc(1);
    chk(32'(req), 32'h1);
    host_dly <= 4'h5;
    host_en <= 1'b1;
    for (n = 0; n < 20 && req !== 3'h0; n++)
      @(posedge clk);
    chk(32'(req), 32'h0);
    rd(`IDX_FLAGS, data, resp);
    chk(data, 32'h0);
    host_en <= 1'b0;
    wr(`IDX_GRP_CTRL, 8'h06, resp);
    pins <= pins ^ live[0];
    cyc(3);
    rd(`IDX_FLAGS, data, resp);
    chk(data, 32'h0);
    wr(`IDX_GRP_CTRL, 8'h07, resp);
    $display("Vector and enable test done");
    host_dly <= 4'h0;
    host_en <= 1'b1;
    for (n = 0; n < 12; n++) begin
      pins <= pins ^ live[0];
      @(posedge clk);
      if (ack[0])
        nacks++;
      if (n > 3)
        chk(32'(req[0]), 32'h1);
    end
    for (n = 0; n < 20 && req !== 3'h0; n++)
      @(posedge clk);
    chk(32'(req), 32'h0);
    chk(32'(nacks > 0), 32'h1);
    $display("Clear collision test done");
    host_en <= 1'b0;
    pins <= pins ^ live[2];
    cyc(3);
    rst <= 1'b1;
    cyc(2);
    chk(32'(req), 32'h0);
    rst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].idx, data, resp);
      chk(data, 32'h0);
    end
    chk(32'(irq), 32'h0);
    $display("Reset test done");
    stop_test();
  end
endmodule
